/* File: verif/bstap_checker.sv */
// Port checker for the test access port
`timescale 1ns/1ps
module bstap_checker
#(
  parameter DR_W = 8
)
(
  input wire            clock_in,
  input wire            rst_b_in,
  input wire            tdo_out,
  input wire            tdo_oe_out,
  input wire [7:0]      ir_active_out,
  input wire            bypass_sel_out,
  input wire [DR_W-1:0] dr_hold_out,
  input wire [3:0]      tap_state_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_oe_on_shift: assert property ($rose(tdo_oe_out) |-> tap_state_out inside {4'h4, 4'hb})
    else $error("drive began outside shift");
  a_oe_off_exit: assert property ($fell(tdo_oe_out) |-> tap_state_out inside {4'h5, 4'hc})
    else $error("drive ended outside exit1");
  a_tdo_quiet: assert property (!tdo_oe_out && !$past(tdo_oe_out) |-> $stable(tdo_out))
    else $error("serial out moved while undriven");
  a_byp_code: assert property ($changed(ir_active_out) |-> ##[0:1]
    bypass_sel_out == (ir_active_out == 8'hff)) else $error("bypass select wrong");
  a_ir_update: assert property ($changed(ir_active_out) |-> tap_state_out inside {4'hf, 4'h0})
    else $error("instruction changed outside update");
  a_hold_update: assert property ($changed(dr_hold_out) |-> tap_state_out == 4'h8)
    else $error("holding stage changed outside update");
  // A test clock phase lasts at least four system clocks, so a state holds that long
  a_state_hold: assert property ($changed(tap_state_out) |=> $stable(tap_state_out) [*3])
    else $error("state moved twice in one test clock");
  a_updr_next: assert property ($changed(tap_state_out) && $past(tap_state_out) == 4'h8
    |-> tap_state_out inside {4'h1, 4'h2}) else $error("bad move from update");
endmodule
bind bstap_top bstap_checker #(.DR_W(DR_W)) bstap_checker_inst (.clock_in, .rst_b_in, .tdo_out,
  .tdo_oe_out, .ir_active_out, .bypass_sel_out, .dr_hold_out, .tap_state_out);

/* File: verif/bstap_ctl.sv */
// Test controller model on the four-wire port
`timescale 1ns/1ps
module bstap_ctl
(
  input  wire clock_in,
  input  wire tdo_in,
  input  wire tdo_oe_in,
  output reg  tck_out,
  output reg  tms_out,
  output reg  tdi_out
);
  reg smp_tdo;
  reg smp_oe;
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // One 160 ns test clock; mode and data move only while the clock is low
  task step(input reg m, input reg d);
  begin
    tms_out <= m;
    tdi_out <= d;
    repeat (4) @(posedge clock_in);
    tck_out <= 1'b1;
    smp_tdo <= tdo_in;
    smp_oe  <= tdo_oe_in;
    repeat (4) @(posedge clock_in);
    tck_out <= 1'b0;
  end
  endtask
endmodule

/* File: verif/bstap_top_bench.sv */
// Self-checking bench for the test access port
`timescale 1ns/1ps
module bstap_top_bench;
  reg         clock_in = 1'b0;
  reg         rst_b_in = 1'b0;
  reg  [7:0]  dr_par = 8'h3c;
  wire        tck, tms, tdi, tdo, tdo_oe, bypass_sel;
  wire [7:0]  ir_active, dr_hold;
  wire [3:0]  tap_state;
  integer     fails = 0;
  integer     checks = 0;
  integer     i;
  reg  [31:0] q;
  // Row: mode, data in, drive seen, bit seen, state after the rise
  reg  [7:0]  rows [0:23] = '{8'h41, 8'hc2, 8'hc9, 8'h4a, 8'h4b, 8'h7b, 8'h6b, 8'h6b, 8'h6b,
    8'h6b, 8'h6b, 8'h6b, 8'hfc, 8'hcf, 8'hc2, 8'h43, 8'h44, 8'h64, 8'h34, 8'he5, 8'hc8, 8'hc2,
    8'hc9, 8'hc0};
  bstap_top bstap_top_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .dr_par_in(dr_par), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .ir_active_out(ir_active),
    .bypass_sel_out(bypass_sel), .dr_hold_out(dr_hold), .tap_state_out(tap_state));
  bstap_ctl bstap_ctl_inst (.clock_in(clock_in), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
    .tms_out(tms), .tdi_out(tdi));
  always #10 clock_in = ~clock_in;
  task chk(input [7:0] got, input [7:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  // Outputs follow a fall by a few system clocks, so a scan waits once at its end
  task seq(input [31:0] m, input [31:0] d, input integer n);
    integer k;
  begin
    for (k = 0; k < n; k = k + 1)
    begin
      bstap_ctl_inst.step(m[k], d[k]);
      q[k] = bstap_ctl_inst.smp_tdo;
    end
    repeat (4) @(posedge clock_in);
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    #100_000;
    fails = fails + 1;
    finish_test;
  end
  initial
  begin
    repeat (3) @(posedge clock_in);
    rst_b_in <= 1'b1;
    chk({tdo_oe, bypass_sel, 2'b00, tap_state}, 8'h40);
    // Each row is checked in the low phase of the next test clock, keeping 160 ns
    for (i = 0; i < 25; i = i + 1)
    begin
      fork
        if (i < 24)
          bstap_ctl_inst.step(rows[i][7], rows[i][6]);
        begin
          repeat (4) @(posedge clock_in);
          if (i > 0)
            chk({2'b00, bstap_ctl_inst.smp_oe, bstap_ctl_inst.smp_oe & bstap_ctl_inst.smp_tdo,
              tap_state}, rows[i-1] & 8'h3f);
        end
      join
    end
    seq(32'h0300_7006, 32'h014a_0000, 26);
    chk(q[12:5], 8'h81);
    chk(q[24:17], dr_par);
    chk(dr_hold, 8'ha5);
    chk({bypass_sel, ir_active[6:0]}, 8'h00);
    seq(32'h0000_0007, 32'h0000_0000, 3);
    chk({ir_active[3:0], tap_state}, 8'hf0);
    seq(32'h0000_0006, 32'h0000_0000, 5);
    chk({tdo_oe, bypass_sel, 2'b00, tap_state}, 8'hcb);
    rst_b_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    chk({tdo_oe, bypass_sel, 2'b00, tap_state}, 8'h40);
    rst_b_in <= 1'b1;
    seq(32'h0000_0000, 32'h0000_0000, 1);
    chk({4'h0, tap_state}, 8'h01);
    finish_test;
  end
endmodule

/* File: verilog/bstap_consts.vh */
// Constants for the boundary-scan test access port
// Notes on behaviour
// - Leaving instruction capture loads the pattern 10000001 into the instruction shifter.
// - The serial output is driven from the falling edge after entering a shift state.
// - In instruction shift each rising edge moves one input bit in and one bit out.
// - The serial output floats from the falling edge after entering an exit1 state.
// - Update-IR loads the active instruction on the falling edge; all ones is bypass.
// - With bypass active, leaving data capture loads a 0 into the bypass stage.
// - Data shift under bypass is a one-stage path, so 101 in gives 010 out.
// - Without bypass, Update-DR copies the shifted data register to its holding stage on the falling edge.
// - Inputs are sampled on rising test clock edges, outputs change on falling edges.
`ifndef BSTAP_CONSTS_VH
`define BSTAP_CONSTS_VH
`define BSTAP_IR_W        8
`define BSTAP_IR_CAPTURE  8'h81
`define BSTAP_IR_BYPASS   8'hff
`define BSTAP_IR_RESET    8'hff
`define BSTAP_DR_W        8
`define BSTAP_DR_RESET    8'h00
`define BSTAP_ST_TLR      4'h0
`define BSTAP_ST_RTI      4'h1
`define BSTAP_ST_SELDR    4'h2
`define BSTAP_ST_CAPDR    4'h3
`define BSTAP_ST_SHDR     4'h4
`define BSTAP_ST_EX1DR    4'h5
`define BSTAP_ST_PAUDR    4'h6
`define BSTAP_ST_EX2DR    4'h7
`define BSTAP_ST_UPDR     4'h8
`define BSTAP_ST_SELIR    4'h9
`define BSTAP_ST_CAPIR    4'ha
`define BSTAP_ST_SHIR     4'hb
`define BSTAP_ST_EX1IR    4'hc
`define BSTAP_ST_PAUIR    4'hd
`define BSTAP_ST_EX2IR    4'he
`define BSTAP_ST_UPIR     4'hf
`endif

/* File: verilog/bstap_sync.v */
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module bstap_sync
(
  input  wire clock_in,
  input  wire rst_b_in,
  input  wire d_in,
  output reg  q_out
);
  reg meta_ff;

  always @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_ff <= 1'b0;
      q_out   <= 1'b0;
    end
    else
    begin
      meta_ff <= d_in;
      q_out   <= meta_ff;
    end
  end
endmodule

/* File: verilog/bstap_top.v */
// Test access port: controller, instruction register, bypass and data register
`timescale 1ns/1ps
`include "bstap_consts.vh"
module bstap_top
#(
  parameter DR_W = `BSTAP_DR_W
)
(
  input  wire            clock_in,
  input  wire            rst_b_in,
  input  wire            tck_in,
  input  wire            tms_in,
  input  wire            tdi_in,
  input  wire [DR_W-1:0] dr_par_in,
  output reg             tdo_out,
  output reg             tdo_oe_out,
  output reg  [7:0]      ir_active_out,
  output reg             bypass_sel_out,
  output reg  [DR_W-1:0] dr_hold_out,
  output reg  [3:0]      tap_state_out
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire tck_s;
  wire tms_s;
  wire tdi_s;

  bstap_sync u_sync_tck
  (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .d_in     (tck_in),
    .q_out    (tck_s)
  );
  bstap_sync u_sync_tms
  (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .d_in     (tms_in),
    .q_out    (tms_s)
  );
  bstap_sync u_sync_tdi
  (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .d_in     (tdi_in),
    .q_out    (tdi_s)
  );

  // ----------------------------------------------------------------
  // Test clock edge detect
  // ----------------------------------------------------------------
  // Sync delay is small against the test clock period, and TMS/TDI go
  // through the same delay, so the sampled values still line up
  reg  tck_d_ff;
  wire tck_rise = tck_s & ~tck_d_ff;
  wire tck_fall = ~tck_s & tck_d_ff;

  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  reg [3:0]      state_ff;
  reg [3:0]      nxt_state;
  reg [7:0]      ir_sh_ff;
  reg [DR_W-1:0] dr_sh_ff;
  reg            byp_ff;

  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      `BSTAP_ST_TLR:   nxt_state = tms_s ? `BSTAP_ST_TLR   : `BSTAP_ST_RTI;
      `BSTAP_ST_RTI:   nxt_state = tms_s ? `BSTAP_ST_SELDR : `BSTAP_ST_RTI;
      `BSTAP_ST_SELDR: nxt_state = tms_s ? `BSTAP_ST_SELIR : `BSTAP_ST_CAPDR;
      `BSTAP_ST_CAPDR: nxt_state = tms_s ? `BSTAP_ST_EX1DR : `BSTAP_ST_SHDR;
      `BSTAP_ST_SHDR:  nxt_state = tms_s ? `BSTAP_ST_EX1DR : `BSTAP_ST_SHDR;
      `BSTAP_ST_EX1DR: nxt_state = tms_s ? `BSTAP_ST_UPDR  : `BSTAP_ST_PAUDR;
      `BSTAP_ST_PAUDR: nxt_state = tms_s ? `BSTAP_ST_EX2DR : `BSTAP_ST_PAUDR;
      `BSTAP_ST_EX2DR: nxt_state = tms_s ? `BSTAP_ST_UPDR  : `BSTAP_ST_SHDR;
      `BSTAP_ST_UPDR:  nxt_state = tms_s ? `BSTAP_ST_SELDR : `BSTAP_ST_RTI;
      `BSTAP_ST_SELIR: nxt_state = tms_s ? `BSTAP_ST_TLR   : `BSTAP_ST_CAPIR;
      `BSTAP_ST_CAPIR: nxt_state = tms_s ? `BSTAP_ST_EX1IR : `BSTAP_ST_SHIR;
      `BSTAP_ST_SHIR:  nxt_state = tms_s ? `BSTAP_ST_EX1IR : `BSTAP_ST_SHIR;
      `BSTAP_ST_EX1IR: nxt_state = tms_s ? `BSTAP_ST_UPIR  : `BSTAP_ST_PAUIR;
      `BSTAP_ST_PAUIR: nxt_state = tms_s ? `BSTAP_ST_EX2IR : `BSTAP_ST_PAUIR;
      `BSTAP_ST_EX2IR: nxt_state = tms_s ? `BSTAP_ST_UPIR  : `BSTAP_ST_SHIR;
      `BSTAP_ST_UPIR:  nxt_state = tms_s ? `BSTAP_ST_SELDR : `BSTAP_ST_RTI;
      default:         nxt_state = `BSTAP_ST_TLR;
    endcase
  end

  // ----------------------------------------------------------------
  // Scan path decode
  // ----------------------------------------------------------------
  // Decoded from the active instruction, so a new code acts only after Update-IR
  wire bypass_now = (ir_active_out == `BSTAP_IR_BYPASS);
  wire shifting   = (state_ff == `BSTAP_ST_SHIR) || (state_ff == `BSTAP_ST_SHDR);

  // ----------------------------------------------------------------
  // Shift stage next values, applied only on a test clock rise
  // ----------------------------------------------------------------
  reg [7:0]      nxt_ir_sh;
  reg [DR_W-1:0] nxt_dr_sh;
  reg            nxt_byp;

  always @*
  begin
    nxt_ir_sh = ir_sh_ff;
    nxt_dr_sh = dr_sh_ff;
    nxt_byp   = byp_ff;
    case (state_ff)
      `BSTAP_ST_CAPIR:
      begin
        nxt_ir_sh = `BSTAP_IR_CAPTURE;
      end
      `BSTAP_ST_SHIR:
      begin
        nxt_ir_sh = {tdi_s, ir_sh_ff[7:1]};
      end
      `BSTAP_ST_CAPDR:
      begin
        // Only the selected register captures; the other keeps its bits
        if (bypass_now)
          nxt_byp = 1'b0;
        else
          nxt_dr_sh = dr_par_in;
      end
      `BSTAP_ST_SHDR:
      begin
        if (bypass_now)
          nxt_byp = tdi_s;
        else
          nxt_dr_sh = {tdi_s, dr_sh_ff[DR_W-1:1]};
      end
      default:
      begin
        nxt_ir_sh = ir_sh_ff;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Rising edge: sample inputs, advance state, shift
  // ----------------------------------------------------------------
  always @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tck_d_ff <= 1'b0;
      state_ff <= `BSTAP_ST_TLR;
      ir_sh_ff <= `BSTAP_IR_RESET;
      dr_sh_ff <= `BSTAP_DR_RESET;
      byp_ff   <= 1'b0;
    end
    else
    begin
      tck_d_ff <= tck_s;
      if (tck_rise)
      begin
        state_ff <= nxt_state;
        ir_sh_ff <= nxt_ir_sh;
        dr_sh_ff <= nxt_dr_sh;
        byp_ff   <= nxt_byp;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output next values, applied only on a test clock fall
  // ----------------------------------------------------------------
  reg            nxt_tdo;
  reg [7:0]      nxt_ir_active;
  reg            nxt_bypass_sel;
  reg [DR_W-1:0] nxt_dr_hold;

  always @*
  begin
    nxt_tdo        = tdo_out;
    nxt_ir_active  = ir_active_out;
    nxt_bypass_sel = bypass_sel_out;
    nxt_dr_hold    = dr_hold_out;
    if (state_ff == `BSTAP_ST_SHIR)
      nxt_tdo = ir_sh_ff[0];
    else if (state_ff == `BSTAP_ST_SHDR)
      nxt_tdo = bypass_now ? byp_ff : dr_sh_ff[0];
    if (state_ff == `BSTAP_ST_TLR)
    begin
      // Reset state forces bypass so no scan path is left half-set
      nxt_ir_active  = `BSTAP_IR_RESET;
      nxt_bypass_sel = 1'b1;
    end
    else if (state_ff == `BSTAP_ST_UPIR)
    begin
      nxt_ir_active  = ir_sh_ff;
      nxt_bypass_sel = (ir_sh_ff == `BSTAP_IR_BYPASS);
    end
    // Bypass has no holding stage, so an update under bypass leaves it alone
    if (state_ff == `BSTAP_ST_UPDR && !bypass_now)
      nxt_dr_hold = dr_sh_ff;
  end

  // ----------------------------------------------------------------
  // Falling edge: outputs and updates
  // ----------------------------------------------------------------
  always @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tdo_out        <= 1'b0;
      tdo_oe_out     <= 1'b0;
      ir_active_out  <= `BSTAP_IR_RESET;
      bypass_sel_out <= 1'b1;
      dr_hold_out    <= `BSTAP_DR_RESET;
      tap_state_out  <= `BSTAP_ST_TLR;
    end
    else if (tck_fall)
    begin
      tap_state_out  <= state_ff;
      tdo_oe_out     <= shifting;
      tdo_out        <= nxt_tdo;
      ir_active_out  <= nxt_ir_active;
      bypass_sel_out <= nxt_bypass_sel;
      dr_hold_out    <= nxt_dr_hold;
    end
  end
endmodule
